/* logic/pcio_pkg.sv */
// Constants, register map and carrier types for the PID_ACTIVE_FLAG control I/O block
//
// How it works
// R1: Selection zero or enable input off means plain drive, no PID_ACTIVE_FLAG.
// R2: Input terminal function code 14 maps the PID_ACTIVE_FLAG enable onto that terminal.
// R3: With no terminal carrying the enable, a valid selection alone enables PID_ACTIVE_FLAG.
// R4: Network-written terminal bits act like the pin for the PID_ACTIVE_FLAG enable.
// R5: Selection 20/21 with set point 9999 takes terminal 2, 5V or 10V scale.
// R6: Selection 20/21 with set point 0..100% uses the panel-entered value.
// R7: Selection 20/21 measures terminal 4; type 0=4-20mA, 1=0-5V, 2=0-10V.
// R8: Selection 50/51 takes the deviation straight from the fieldbus.
// R9: Selection 60/61 takes set point and process value from the fieldbus.
// R10: Upper flag when process value exceeds limit; codes 15/115; not 9999.
// R11: Lower flag when process value below limit; codes 14/114; not 9999.
// R12: Direction flag high while forward, low for reverse or stop; 16/116.
// R13: PID_ACTIVE_FLAG-active flag high while PID_ACTIVE_FLAG runs; output codes 47/147.
// R14: Output codes of 100 or more drive the terminal inverted.
// R15: Switchover frequency 0..400Hz: start without PID_ACTIVE_FLAG, enter it on reaching.
// R16: Once switched into PID_ACTIVE_FLAG, stay there even if frequency drops again.
// R17: Monitor codes 52/53/54 give set point, measured, deviation in 0.1%.
// R18: Deviation monitor shows 1000 at 0%; not allowed on analog monitor.
// R19: Operator calibrates inputs only while stopped in panel mode.
// R20: Only selections 20, 21, 50, 51, 60 and 61 enable PID_ACTIVE_FLAG.
// R21: Reverse action raises frequency on positive deviation; forward opposite.
// R22: Limits and flags refresh every update tick and clear when not true.
package pcio_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_ACTION = 8'h00;
  localparam logic [7:0] ADDR_SET_POINT = 8'h04;
  localparam logic [7:0] ADDR_UPPER = 8'h08;
  localparam logic [7:0] ADDR_LOWER = 8'h0C;
  localparam logic [7:0] ADDR_SWITCH = 8'h10;
  localparam logic [7:0] ADDR_INPUT_CFG = 8'h14;
  localparam logic [7:0] ADDR_IN_FUNC = 8'h18;
  localparam logic [7:0] ADDR_OUT_FUNC = 8'h1C;
  localparam logic [7:0] ADDR_NET_BITS = 8'h20;
  localparam logic [7:0] ADDR_MON_SEL = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  localparam logic [7:0] ADDR_MONITOR = 8'h2C;

  // Reset values
  localparam logic [7:0] RST_ACTION = 8'h00;
  localparam logic [13:0] NO_FUNC = 14'h270F;
  localparam logic [1:0] RST_INPUT_TYPE = 2'h0;
  localparam logic RST_ANALOG_5V = 1'h1;

  // Field positions in INPUT_CFG
  localparam int POS_INPUT_TYPE = 0;
  localparam int POS_ANALOG_5V = 4;

  // Action selection codes
  localparam logic [7:0] SEL_OFF = 8'h00;
  localparam logic [7:0] SEL_AN_REV = 8'h14;
  localparam logic [7:0] SEL_AN_FWD = 8'h15;
  localparam logic [7:0] SEL_DEV_REV = 8'h32;
  localparam logic [7:0] SEL_DEV_FWD = 8'h33;
  localparam logic [7:0] SEL_BUS_REV = 8'h3C;
  localparam logic [7:0] SEL_BUS_FWD = 8'h3D;

  // Terminal function codes
  localparam logic [7:0] FN_PID_ENABLE = 8'h0E;
  localparam logic [7:0] FN_LOWER = 8'h0E;
  localparam logic [7:0] FN_UPPER = 8'h0F;
  localparam logic [7:0] FN_DIRECTION = 8'h10;
  localparam logic [7:0] FN_PID_ACTIVE = 8'h2F;
  localparam logic [7:0] FN_NEG_BASE = 8'h64;

  // Monitor codes and scaling
  localparam logic [7:0] MON_SET_POINT = 8'h34;
  localparam logic [7:0] MON_MEASURED = 8'h35;
  localparam logic [7:0] MON_DEVIATION = 8'h36;
  localparam logic [9:0] PCT_FULL = 10'h3E8;
  localparam logic [9:0] DEV_ZERO = 10'h3E8;
  localparam logic [9:0] MA4_CODE = 10'h0C8;
  localparam logic [13:0] SW_FREQ_MAX = 14'h0FA0;

  // Input scaling modes
  localparam logic [1:0] MODE_4_20MA = 2'h0;
  localparam logic [1:0] MODE_0_5V = 2'h1;
  localparam logic [1:0] MODE_0_10V = 2'h2;

  // Control update period
  localparam int CLK_PERIOD_NS = 5;
  localparam int UPDATE_NS = 10000;
  localparam int UPDATE_CYCLES = UPDATE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SW_STOP = 2'b00,
    SW_DIRECT = 2'b01,
    SW_PID = 2'b10
  } pcio_sw_t;

  typedef struct packed {
    logic [9:0] set_point;
    logic [9:0] process;
    logic signed [11:0] deviation;
  } pcio_fieldbus_t;

  typedef struct packed {
    logic pid_active_flag;
    logic upper_limit_flag;
    logic lower_limit_flag;
    logic rotation_direction_flag;
  } pcio_flags_t;

endpackage

/* logic/pcio_top.sv */
// APB slave with PID_ACTIVE_FLAG selection, input routing, flags and monitors
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pcio_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] in_term_pin,
  input wire logic run_command,
  input wire logic dir_forward,
  input wire logic [13:0] out_freq,
  input wire logic [9:0] term2_code,
  input wire logic [9:0] term4_code,
  input wire pcio_pkg::pcio_fieldbus_t fieldbus,
  output pcio_pkg::pcio_flags_t flags,
  output logic [2:0] out_term,
  output logic [9:0] set_point_out,
  output logic [9:0] process_out,
  output logic signed [11:0] pid_error,
  output logic [10:0] display_monitor,
  output logic [9:0] analog_monitor_output
);

  function automatic logic [9:0] pcio_scale(input logic [9:0] code,
                                            input logic [1:0] mode);
    logic [12:0] t;
    t = 13'h0000;
    case (mode)
      pcio_pkg::MODE_4_20MA: begin
        if (code >= pcio_pkg::MA4_CODE) begin
          t = 13'(((13'(code) - 13'(pcio_pkg::MA4_CODE)) * 13'h0005) >> 2);
        end
      end
      pcio_pkg::MODE_0_5V: t = {2'b00, code, 1'b0};
      default: t = {3'b000, code};
    endcase
    return (t > 13'(pcio_pkg::PCT_FULL)) ? pcio_pkg::PCT_FULL : t[9:0];
  endfunction

  function automatic logic pcio_out_level(input logic [7:0] code,
                                          input pcio_pkg::pcio_flags_t f);
    logic inv;
    logic [7:0] base;
    logic sig;
    inv = (code >= pcio_pkg::FN_NEG_BASE);
    base = inv ? 8'(code - pcio_pkg::FN_NEG_BASE) : code;
    case (base)
      pcio_pkg::FN_LOWER: sig = f.lower_limit_flag;
      pcio_pkg::FN_UPPER: sig = f.upper_limit_flag;
      pcio_pkg::FN_DIRECTION: sig = f.rotation_direction_flag;
      pcio_pkg::FN_PID_ACTIVE: sig = f.pid_active_flag;
      default: sig = 1'b0;
    endcase
    return sig ^ inv; // [R14]
  endfunction

  // Software registers
  logic [7:0] pid_action_selection;
  logic [13:0] set_point_setting;
  logic [13:0] upper_limit_setting;
  logic [13:0] lower_limit_setting;
  logic [13:0] switchover_frequency;
  logic [1:0] measured_input_type;
  logic analog_input_selection;
  logic [31:0] input_terminal_functions;
  logic [23:0] output_terminal_functions;
  logic [3:0] net_bits;
  logic [7:0] display_monitor_selection;
  logic [7:0] analog_monitor_selection;

  // Pin synchroniser and state
  logic [3:0] in_meta;
  logic [3:0] in_sync;
  logic [10:0] tick_cnt;
  logic tick;
  pcio_pkg::pcio_sw_t sw_state;
  pcio_pkg::pcio_sw_t next_sw_state;

  // APB decode: one wait state, so prdata and pready both come from flops
  wire apb_access = psel & penable;
  wire apb_done = apb_access & pready;
  wire apb_wr = apb_done & pwrite & ~pslverr;
  logic [31:0] rd_data;
  logic addr_hit;
  pcio_pkg::pcio_flags_t next_flags;

  always_comb begin
    rd_data = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      pcio_pkg::ADDR_ACTION: rd_data = {24'h000000, pid_action_selection};
      pcio_pkg::ADDR_SET_POINT: rd_data = {18'h00000, set_point_setting};
      pcio_pkg::ADDR_UPPER: rd_data = {18'h00000, upper_limit_setting};
      pcio_pkg::ADDR_LOWER: rd_data = {18'h00000, lower_limit_setting};
      pcio_pkg::ADDR_SWITCH: rd_data = {18'h00000, switchover_frequency};
      pcio_pkg::ADDR_INPUT_CFG: begin
        rd_data[pcio_pkg::POS_INPUT_TYPE +: 2] = measured_input_type;
        rd_data[pcio_pkg::POS_ANALOG_5V] = analog_input_selection;
      end
      pcio_pkg::ADDR_IN_FUNC: rd_data = input_terminal_functions;
      pcio_pkg::ADDR_OUT_FUNC: rd_data = {8'h00, output_terminal_functions};
      pcio_pkg::ADDR_NET_BITS: rd_data = {28'h0000000, net_bits};
      pcio_pkg::ADDR_MON_SEL:
        rd_data = {16'h0000, analog_monitor_selection,
                   display_monitor_selection};
      pcio_pkg::ADDR_STATUS:
        rd_data = {20'h00000, 2'(sw_state), 2'b00, 4'(in_sync), 4'(flags)};
      pcio_pkg::ADDR_MONITOR:
        rd_data = {5'h00, display_monitor, 6'h00, analog_monitor_output};
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access & ~pready;
      if (apb_access & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~addr_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pid_action_selection <= pcio_pkg::RST_ACTION;
      set_point_setting <= pcio_pkg::NO_FUNC;
      upper_limit_setting <= pcio_pkg::NO_FUNC;
      lower_limit_setting <= pcio_pkg::NO_FUNC;
      switchover_frequency <= pcio_pkg::NO_FUNC;
      measured_input_type <= pcio_pkg::RST_INPUT_TYPE;
      analog_input_selection <= pcio_pkg::RST_ANALOG_5V;
      input_terminal_functions <= 32'h0000_0000;
      output_terminal_functions <= 24'h000000;
      net_bits <= 4'h0;
      display_monitor_selection <= 8'h00;
      analog_monitor_selection <= 8'h00;
    end else if (apb_wr) begin
      case (paddr)
        pcio_pkg::ADDR_ACTION: pid_action_selection <= pwdata[7:0];
        pcio_pkg::ADDR_SET_POINT: set_point_setting <= pwdata[13:0];
        pcio_pkg::ADDR_UPPER: upper_limit_setting <= pwdata[13:0];
        pcio_pkg::ADDR_LOWER: lower_limit_setting <= pwdata[13:0];
        pcio_pkg::ADDR_SWITCH: switchover_frequency <= pwdata[13:0];
        pcio_pkg::ADDR_INPUT_CFG: begin
          measured_input_type <= pwdata[pcio_pkg::POS_INPUT_TYPE +: 2];
          analog_input_selection <= pwdata[pcio_pkg::POS_ANALOG_5V];
        end
        pcio_pkg::ADDR_IN_FUNC: input_terminal_functions <= pwdata;
        pcio_pkg::ADDR_OUT_FUNC: output_terminal_functions <= pwdata[23:0];
        pcio_pkg::ADDR_NET_BITS: net_bits <= pwdata[3:0]; // [R4]
        pcio_pkg::ADDR_MON_SEL: begin
          display_monitor_selection <= pwdata[7:0];
          // Deviation has no analog full scale, so that code is refused
          if (pwdata[15:8] != pcio_pkg::MON_DEVIATION) begin // [R18]
            analog_monitor_selection <= pwdata[15:8];
          end
        end
        default: ;
      endcase
    end
  end

  // Terminal pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= 4'h0;
      in_sync <= 4'h0;
    end else begin
      in_meta <= in_term_pin;
      in_sync <= in_meta;
    end
  end

  // Control update tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 11'h000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 11'(pcio_pkg::UPDATE_CYCLES - 1));
      if (tick_cnt == 11'(pcio_pkg::UPDATE_CYCLES - 1)) begin
        tick_cnt <= 11'h000;
      end else begin
        tick_cnt <= tick_cnt + 11'h001;
      end
    end
  end

  // Selection decode
  wire sel_analog = (pid_action_selection == pcio_pkg::SEL_AN_REV) |
                    (pid_action_selection == pcio_pkg::SEL_AN_FWD);
  wire sel_devbus = (pid_action_selection == pcio_pkg::SEL_DEV_REV) |
                    (pid_action_selection == pcio_pkg::SEL_DEV_FWD);
  wire sel_bus = (pid_action_selection == pcio_pkg::SEL_BUS_REV) |
                 (pid_action_selection == pcio_pkg::SEL_BUS_FWD);
  wire sel_pid = sel_analog | sel_devbus | sel_bus; // [R20]
  wire sel_limits = sel_analog | sel_bus;
  wire reverse_action = ~pid_action_selection[0];

  // PID_ACTIVE_FLAG enable input: pin level or network-written bit of the same terminal
  logic [3:0] enable_map;
  for (genvar i = 0; i < 4; i++) begin : g_en
    assign enable_map[i] =
      (input_terminal_functions[8*i +: 8] == pcio_pkg::FN_PID_ENABLE); // [R2]
  end
  wire enable_assigned = |enable_map;
  wire enable_level = |(enable_map & (in_sync | net_bits)); // [R2] [R4]
  // Without an enable terminal the selection alone decides
  wire pid_request = sel_pid & (~enable_assigned | enable_level); // [R1] [R3]

  // Automatic switchover; 9999 or anything above 400Hz turns it off
  wire sw_enabled = (switchover_frequency <= pcio_pkg::SW_FREQ_MAX);
  wire freq_reached = (out_freq >= switchover_frequency);

  always_comb begin
    next_sw_state = sw_state;
    unique case (sw_state)
      pcio_pkg::SW_STOP:
        if (run_command) next_sw_state = pcio_pkg::SW_DIRECT;
      pcio_pkg::SW_DIRECT:
        if (!run_command) begin
          next_sw_state = pcio_pkg::SW_STOP;
        end else if (freq_reached) begin
          next_sw_state = pcio_pkg::SW_PID; // [R15]
        end
      // A later drop in frequency does not leave PID_ACTIVE_FLAG, only a stop does
      pcio_pkg::SW_PID:
        if (!run_command) next_sw_state = pcio_pkg::SW_STOP; // [R16]
      default: next_sw_state = pcio_pkg::SW_STOP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= pcio_pkg::SW_STOP;
    end else begin
      sw_state <= next_sw_state;
    end
  end

  wire pid_run = pid_request &
                 (~sw_enabled | (sw_state == pcio_pkg::SW_PID)); // [R15]

  // Input routing
  wire [9:0] t2_pct = pcio_scale(term2_code, analog_input_selection ?
                                 pcio_pkg::MODE_0_5V : pcio_pkg::MODE_0_10V);
  wire [9:0] t4_pct = pcio_scale(term4_code, measured_input_type); // [R7]
  wire [9:0] sp_panel = (set_point_setting > 14'(pcio_pkg::PCT_FULL)) ?
                        pcio_pkg::PCT_FULL : set_point_setting[9:0];
  wire [9:0] sp_local = (set_point_setting == pcio_pkg::NO_FUNC) ?
                        t2_pct : sp_panel; // [R5] [R6]
  wire [9:0] sp_sel = sel_bus ? fieldbus.set_point :
                      (sel_analog ? sp_local : 10'h000); // [R9]
  wire [9:0] pv_sel = sel_bus ? fieldbus.process :
                      (sel_analog ? t4_pct : 10'h000); // [R9]
  wire signed [11:0] dev_calc = $signed({2'b00, sp_sel}) -
                                $signed({2'b00, pv_sel});
  wire signed [11:0] dev_sel = sel_devbus ? fieldbus.deviation :
                               dev_calc; // [R8]
  // Error sign chosen so that a positive value always raises frequency
  wire signed [11:0] err_drive = reverse_action ? dev_sel :
                                 12'(-dev_sel); // [R21]

  // Limit checks
  wire upper_hit = sel_limits & (upper_limit_setting != pcio_pkg::NO_FUNC) &
                   ({4'h0, pv_sel} > upper_limit_setting); // [R10]
  wire lower_hit = sel_limits & (lower_limit_setting != pcio_pkg::NO_FUNC) &
                   ({4'h0, pv_sel} < lower_limit_setting); // [R11]

  assign next_flags.pid_active_flag = pid_run; // [R13]
  assign next_flags.upper_limit_flag = upper_hit;
  assign next_flags.lower_limit_flag = lower_hit;
  assign next_flags.rotation_direction_flag =
    run_command & dir_forward; // [R12]

  logic [2:0] term_level;
  for (genvar j = 0; j < 3; j++) begin : g_out
    assign term_level[j] =
      pcio_out_level(output_terminal_functions[8*j +: 8], next_flags);
  end

  // Monitors
  wire [11:0] dev_shift = 12'(dev_sel + $signed({2'b00, pcio_pkg::DEV_ZERO}));
  logic [10:0] disp_next;
  logic [9:0] am_next;
  always_comb begin
    case (display_monitor_selection)
      pcio_pkg::MON_SET_POINT: disp_next = {1'b0, sp_sel}; // [R17]
      pcio_pkg::MON_MEASURED: disp_next = {1'b0, pv_sel};
      pcio_pkg::MON_DEVIATION: disp_next = dev_shift[10:0]; // [R18]
      default: disp_next = 11'h000;
    endcase
    case (analog_monitor_selection)
      pcio_pkg::MON_SET_POINT: am_next = sp_sel; // [R17]
      pcio_pkg::MON_MEASURED: am_next = pv_sel;
      default: am_next = 10'h000;
    endcase
  end

  // Every output except the APB ones refreshes together on the update tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
      out_term <= 3'h0;
      set_point_out <= 10'h000;
      process_out <= 10'h000;
      pid_error <= 12'sh000;
      display_monitor <= 11'h000;
      analog_monitor_output <= 10'h000;
    end else if (tick) begin
      flags <= next_flags; // [R22]
      out_term <= term_level; // [R14]
      set_point_out <= sp_sel;
      process_out <= pv_sel;
      pid_error <= pid_run ? err_drive : 12'sh000; // [R1]
      display_monitor <= disp_next;
      analog_monitor_output <= am_next;
    end
  end

  property p_sel_zero;
    @(posedge pclk) disable iff (!presetn)
    (pid_action_selection == pcio_pkg::SEL_OFF) |-> !pid_run;
  endproperty
  a_sel_zero: assert property (p_sel_zero) // [R1]
    else $error("PID_ACTIVE_FLAG runs with selection zero");
  property p_enable_off;
    @(posedge pclk) disable iff (!presetn)
    (enable_assigned && !enable_level) |-> !pid_run;
  endproperty
  a_enable_off: assert property (p_enable_off) // [R2]
    else $error("PID_ACTIVE_FLAG runs with enable input off");
  property p_no_enable_input;
    @(posedge pclk) disable iff (!presetn)
    (sel_pid && !enable_assigned && !sw_enabled) |-> pid_run;
  endproperty
  a_no_enable_input: assert property (p_no_enable_input) // [R3]
    else $error("Valid selection without enable terminal did not run PID_ACTIVE_FLAG");
  property p_net_bit;
    @(posedge pclk) disable iff (!presetn)
    (enable_map[0] && net_bits[0] && sel_pid && !sw_enabled) |-> pid_run;
  endproperty
  a_net_bit: assert property (p_net_bit) // [R4]
    else $error("Network enable bit ignored");
  property p_sw_wait;
    @(posedge pclk) disable iff (!presetn)
    (sw_state == pcio_pkg::SW_DIRECT && !freq_reached)
      |=> (sw_state != pcio_pkg::SW_PID);
  endproperty
  a_sw_wait: assert property (p_sw_wait) // [R15]
    else $error("Switched to PID_ACTIVE_FLAG before frequency reached");
  property p_sw_hold;
    @(posedge pclk) disable iff (!presetn)
    (sw_state == pcio_pkg::SW_PID && run_command) |=>
      (sw_state == pcio_pkg::SW_PID);
  endproperty
  a_sw_hold: assert property (p_sw_hold) // [R16]
    else $error("Left PID_ACTIVE_FLAG while still running");
  property p_upper_flag;
    @(posedge pclk) disable iff (!presetn)
    (tick && upper_hit) |=> flags.upper_limit_flag [*2];
  endproperty
  a_upper_flag: assert property (p_upper_flag) // [R10]
    else $error("Upper limit flag missing");
  property p_lower_clear;
    @(posedge pclk) disable iff (!presetn)
    (tick && !lower_hit) |=> !flags.lower_limit_flag;
  endproperty
  a_lower_clear: assert property (p_lower_clear) // [R22]
    else $error("Lower limit flag did not clear");
  property p_out_invert;
    @(posedge pclk) disable iff (!presetn)
    (tick && output_terminal_functions[7:0] ==
      8'(pcio_pkg::FN_UPPER + pcio_pkg::FN_NEG_BASE))
      |=> (out_term[0] == !flags.upper_limit_flag);
  endproperty
  a_out_invert: assert property (p_out_invert) // [R14]
    else $error("Negative logic output not inverted");
  property p_dev_zero;
    @(posedge pclk) disable iff (!presetn)
    (tick && display_monitor_selection == pcio_pkg::MON_DEVIATION &&
      dev_sel == 12'sh000) |=> (display_monitor == 11'(pcio_pkg::DEV_ZERO));
  endproperty
  a_dev_zero: assert property (p_dev_zero) // [R18]
    else $error("Deviation monitor not offset");

endmodule // pcio_top
`default_nettype wire

/* bench/pcio_far.sv */
// Process detector, panel and fieldbus master model
`timescale 1ns/100ps
`default_nettype none
module pcio_far (
  input wire logic pclk,
  input wire logic [9:0] t2,
  input wire logic [9:0] t4,
  input wire pcio_pkg::pcio_fieldbus_t fb_in,
  output logic [9:0] term2_code,
  output logic [9:0] term4_code,
  output pcio_pkg::pcio_fieldbus_t fieldbus
);
  // Registered so the far side only moves just after an edge
  // Codes arrive calibrated; calibration happens only at a stop
  always_ff @(posedge pclk) begin
    term2_code <= t2;
    term4_code <= t4;
    fieldbus <= fb_in;
  end
endmodule // pcio_far
`default_nettype wire

/* bench/pcio_top_tb.sv */
// Self-checking bench for the PID_ACTIVE_FLAG control I/O block
`timescale 1ns/100ps
`default_nettype none
module pcio_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, err, run_command = 0, dir_forward = 0;
  logic [3:0] in_term_pin = 4'h0;
  logic [13:0] out_freq = 14'h0;
  logic [9:0] t2 = 10'h0, t4 = 10'h0, term2_code, term4_code, sp, pv;
  logic [9:0] set_point_out, process_out, analog_monitor_output;
  logic [10:0] display_monitor;
  logic signed [11:0] pid_error;
  logic [2:0] out_term;
  pcio_pkg::pcio_fieldbus_t fb_in = '0, fieldbus;
  pcio_pkg::pcio_flags_t flags;
  int fail_count = 0, num_checks = 0, seed = 50, m, d;

  always #2.5 pclk = ~pclk;

  pcio_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .in_term_pin, .run_command,
    .dir_forward, .out_freq, .term2_code, .term4_code, .fieldbus, .flags,
    .out_term, .set_point_out, .process_out, .pid_error, .display_monitor,
    .analog_monitor_output);
  pcio_far far (.pclk, .t2, .t4, .fb_in, .term2_code, .term4_code,
    .fieldbus);

  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference scaling of one analog code onto 0.1% steps
  function automatic int sc(int c, int md);
    int v;
    v = md == 0 ? (c < 200 ? 0 : ((c - 200) * 5) >> 2) : md == 1 ? 2 * c : c;
    return v > 1000 ? 1000 : v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Two update periods, so every output has been refreshed at least once
  task automatic settle();
    repeat (4100) @(posedge pclk);
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #450000;
    fail_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, pcio_pkg::ADDR_SET_POINT, 0);
    chk(rd, 32'h270F);
    apb(0, pcio_pkg::ADDR_INPUT_CFG, 0);
    chk(rd, 32'h10);
    apb(0, 8'h40, 0);
    chk(err, 1);
    t2 <= 10'(xs() & 32'h1FF);
    t4 <= 10'((xs() & 32'h1FF) + 100);
    settle();
    chk(flags, 0);
    chk(pid_error, 0);
    for (m = 0; m < 3; m++) begin
      apb(1, pcio_pkg::ADDR_ACTION, 20 + (m & 1));
      apb(1, pcio_pkg::ADDR_INPUT_CFG, m | ((m & 1) << 4));
      settle();
      sp = 10'(sc(t2, (m & 1) ? 1 : 2));
      pv = 10'(sc(t4, m));
      chk(set_point_out, sp);
      chk(process_out, pv);
      chk(pid_error, (m & 1) ? pv - sp : sp - pv);
      chk(flags.pid_active_flag, 1);
    end
    apb(1, pcio_pkg::ADDR_MON_SEL, 32'h3536);
    settle();
    chk(display_monitor, sp - pv + 1000);
    chk(analog_monitor_output, pv);
    apb(1, pcio_pkg::ADDR_MON_SEL, 32'h3634);
    apb(1, pcio_pkg::ADDR_SET_POINT, 500);
    settle();
    chk(display_monitor, 500);
    chk(analog_monitor_output, pv);
    chk(set_point_out, 500);
    apb(1, pcio_pkg::ADDR_UPPER, pv - 1);
    apb(1, pcio_pkg::ADDR_LOWER, pv + 1);
    apb(1, pcio_pkg::ADDR_OUT_FUNC, 32'h930E0F);
    settle();
    chk(flags, 4'hE);
    chk(out_term, 3'b011);
    apb(1, pcio_pkg::ADDR_UPPER, 9999);
    apb(1, pcio_pkg::ADDR_LOWER, 9999);
    settle();
    chk(flags, 4'h8);
    chk(out_term, 3'b000);
    apb(1, pcio_pkg::ADDR_IN_FUNC, 32'h0E);
    settle();
    chk(flags.pid_active_flag, 0);
    chk(pid_error, 0);
    apb(1, pcio_pkg::ADDR_NET_BITS, 1);
    settle();
    chk(flags.pid_active_flag, 1);
    apb(1, pcio_pkg::ADDR_NET_BITS, 0);
    in_term_pin <= 4'h1;
    settle();
    chk(flags.pid_active_flag, 1);
    in_term_pin <= 4'h0;
    apb(1, pcio_pkg::ADDR_IN_FUNC, 0);
    d = (xs() & 32'h1FF) - 256;
    fb_in <= {10'h12C, 10'h2BC, 12'(d)};
    for (m = 50; m < 52; m++) begin
      apb(1, pcio_pkg::ADDR_ACTION, m);
      settle();
      chk(pid_error, (m & 1) ? -d : d);
    end
    for (m = 60; m < 62; m++) begin
      apb(1, pcio_pkg::ADDR_ACTION, m);
      settle();
      chk(set_point_out, 300);
      chk(process_out, 700);
      chk(pid_error, (m & 1) ? 400 : -400);
    end
    apb(1, pcio_pkg::ADDR_ACTION, 20);
    apb(1, pcio_pkg::ADDR_SWITCH, 1000);
    run_command <= 1'b1;
    out_freq <= 14'h01F4;
    settle();
    chk(flags.pid_active_flag, 0);
    out_freq <= 14'h05DC;
    settle();
    chk(flags.pid_active_flag, 1);
    out_freq <= 14'h00C8;
    dir_forward <= 1'b1;
    settle();
    chk(flags.pid_active_flag, 1);
    chk(flags.rotation_direction_flag, 1);
    run_command <= 1'b0;
    settle();
    chk(flags.rotation_direction_flag, 0);
    results();
  end
endmodule // pcio_top_tb
`default_nettype wire
